// file: core/gpcd_port.sv
// Two-port GPIO with change detection on pins 7:4, APB register access
//
// How it works
// - Second port eight independent bidirectional pins
// - Direction one tristates, zero drives latch
// - Latch register readable, returns latched value
// - Active-low bit enables second-port pull-ups
// - Output pins never get pull-up
// - Pull-ups disabled after reset
// - Pins 3:0 analog zero, 7:4 digital
// - Only input pins 7:4 compared
// - Mismatches ORed set change flag bit0
// - Change flag drives wake output
// - Mismatch keeps setting; clear dropped in the cycle after a pin access
// - Analog select disables third-port digital input
// - Output latch drives despite analog select
// - Third-port pins analog after reset
// - Third-port pin and latch registers implement bits 2:0 only
// - Direction bit7 enables fourth-port pull-ups
// - Direction bit6 enables third-port pull-ups
//
// Chosen here: the APB interface to the registers and the address map.
`default_nettype none
`include "gpcd_params.svh"

module gpcd_port
   import gpcd_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic [7:0]  p2_pad_in,
   output logic [7:0]       p2_pad_out,
   output logic [7:0]       p2_pad_oe_n,
   output logic [7:0]       p2_pullup_on,
   input  wire logic [2:0]  p3_pad_in,
   output logic [2:0]       p3_pad_out,
   output logic [2:0]       p3_pad_oe_n,
   output logic [2:0]       p3_pullup_on,
   output logic             p4_pullup_enable,
   output logic [7:0]       analog_select,
   output logic             wake_req
);

   gpcd_state_s st_r;
   gpcd_state_s st_nxt;

   logic [7:0]  p2_digital;
   logic [7:0]  p2_read;
   logic [7:0]  p2_watch;
   logic [7:0]  p2_ref_pin;
   logic [7:0]  p2_miss;
   logic [2:0]  p3_read;
   logic        setup;
   logic        wr_acc;
   logic        rd_acc;
   logic        mapped;
   logic        pin_acc;
   logic        flag_wr;
   logic        clr_req;
   logic        set_req;
   logic        clr_ok;
   logic [31:0] rd_word;

   // ************************************************************
   // Pin logic
   // ************************************************************
   // Pins 3:0 read zero while analog
   assign p2_digital = {4'hf, ~st_r.ansel[3:0]};
   // Only input pins 7:4 join the compare
   assign p2_watch   = {st_r.p2_dir[7:4], 4'h0};
   assign p2_ref_pin = {st_r.p2_ref, 4'h0};
   assign p4_pullup_enable = st_r.p4_pu;
   assign analog_select    = st_r.ansel;
   assign wake_req         = st_r.chg_flag;

   // ************************************************************
   // Pad cells
   // ************************************************************
   // Second port: full pad with change compare
   for (genvar i = 0; i < 8; i++) begin : g_p2_pad
      gpcd_pad_cell u_pad (
         .pad_in    (p2_pad_in[i]),
         .lat       (st_r.p2_lat[i]),
         .dir       (st_r.p2_dir[i]),
         .pu_req    (~st_r.puen_n),
         .analog    (~p2_digital[i]),
         .ref_val   (p2_ref_pin[i]),
         .watch     (p2_watch[i]),
         .pad_out   (p2_pad_out[i]),
         .pad_oe_n  (p2_pad_oe_n[i]),
         .pullup_on (p2_pullup_on[i]),
         .din       (p2_read[i]),
         .miss      (p2_miss[i])
      );
   end

   // Third port has no change compare
   for (genvar i = 0; i < 3; i++) begin : g_p3_pad
      gpcd_pad_cell u_pad (
         .pad_in    (p3_pad_in[i]),
         .lat       (st_r.p3_lat[i]),
         .dir       (st_r.p3_dir[i]),
         .pu_req    (st_r.p3_pu),
         .analog    (st_r.ansel[i+5]),
         .ref_val   (1'b0),
         .watch     (1'b0),
         .pad_out   (p3_pad_out[i]),
         .pad_oe_n  (p3_pad_oe_n[i]),
         .pullup_on (p3_pullup_on[i]),
         .din       (p3_read[i]),
         .miss      ()
      );
   end

   // ************************************************************
   // Change detection
   // ************************************************************
   // Pin register access, read or write
   assign pin_acc = (rd_acc || wr_acc) && (paddr == `GPCD_OFF_P2_PINS);
   assign flag_wr = wr_acc && (paddr == `GPCD_OFF_INTCTL);
   assign clr_req = flag_wr && !pwdata[`GPCD_BIT_CHG_FLAG];
   assign set_req = flag_wr && pwdata[`GPCD_BIT_CHG_FLAG];
   // A clear just after a pin access is dropped
   assign clr_ok  = clr_req && (st_r.clr_hold == 2'h0);

   // ************************************************************
   // APB decode
   // ************************************************************
   // Setup decoded, access answers next cycle
   assign setup   = psel && !penable;
   // One access cycle, no wait states
   assign pready  = (st_r.bus == GPCD_ACCESS);
   assign wr_acc  = psel && penable && pready && pwrite;
   assign rd_acc  = psel && penable && pready && !pwrite;
   assign prdata  = st_r.prdata;

   // Mapped register offsets
   always_comb begin
      case (paddr)
         `GPCD_OFF_P2_PINS,
         `GPCD_OFF_P2_LAT,
         `GPCD_OFF_P2_DIR,
         `GPCD_OFF_INTCTL,
         `GPCD_OFF_INTCTL2,
         `GPCD_OFF_P3_PINS,
         `GPCD_OFF_P3_LAT,
         `GPCD_OFF_P3_DIR,
         `GPCD_OFF_ANSEL,
         `GPCD_OFF_WAKE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Error only in the access cycle of an unmapped address
   assign pslverr = pready && psel && penable && !mapped;

   // ************************************************************
   // Read data mux
   // ************************************************************
   // Decoded in setup so data stands in the access cycle
   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         `GPCD_OFF_P2_PINS: begin
            rd_word[7:0] = p2_read;
         end
         `GPCD_OFF_P2_LAT: begin
            rd_word[7:0] = st_r.p2_lat;
         end
         `GPCD_OFF_P2_DIR: begin
            rd_word[7:0] = st_r.p2_dir;
         end
         `GPCD_OFF_INTCTL: begin
            rd_word[`GPCD_BIT_CHG_FLAG] = st_r.chg_flag;
         end
         `GPCD_OFF_INTCTL2: begin
            rd_word[`GPCD_BIT_PUEN_N] = st_r.puen_n;
         end
         `GPCD_OFF_P3_PINS: begin
            rd_word[2:0] = p3_read;
         end
         `GPCD_OFF_P3_LAT: begin
            rd_word[2:0] = st_r.p3_lat;
         end
         `GPCD_OFF_P3_DIR: begin
            // Pull-up enables sit above the direction bits
            rd_word[7:0] = {st_r.p4_pu, st_r.p3_pu, 3'h0, st_r.p3_dir};
         end
         `GPCD_OFF_ANSEL: begin
            rd_word[7:0] = st_r.ansel;
         end
         `GPCD_OFF_WAKE: begin
            rd_word[0] = st_r.chg_flag;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_nxt = st_r;

      case (st_r.bus)
         GPCD_IDLE: begin
            if (setup) begin
               st_nxt.bus    = GPCD_ACCESS;
               st_nxt.prdata = rd_word;
            end
         end
         GPCD_ACCESS: begin
            st_nxt.bus = GPCD_IDLE;
         end
         default: begin
            st_nxt.bus = GPCD_IDLE;
         end
      endcase

      // Clear guard counts down one cycle
      if (st_r.clr_hold != 2'h0) begin
         st_nxt.clr_hold = st_r.clr_hold - 2'h1;
      end

      // Any access to the pin register refreshes the reference
      if (pin_acc) begin
         st_nxt.p2_ref   = p2_read[7:4];
         st_nxt.clr_hold = `GPCD_CLR_HOLD;
      end

      // Writes land at the completion edge
      if (wr_acc) begin
         case (paddr)
            `GPCD_OFF_P2_PINS: begin
               st_nxt.p2_lat = pwdata[7:0];
            end
            `GPCD_OFF_P2_LAT: begin
               st_nxt.p2_lat = pwdata[7:0];
            end
            `GPCD_OFF_P2_DIR: begin
               st_nxt.p2_dir = pwdata[7:0];
            end
            `GPCD_OFF_INTCTL2: begin
               st_nxt.puen_n = pwdata[`GPCD_BIT_PUEN_N];
            end
            `GPCD_OFF_P3_PINS: begin
               st_nxt.p3_lat = pwdata[2:0];
            end
            `GPCD_OFF_P3_LAT: begin
               st_nxt.p3_lat = pwdata[2:0];
            end
            `GPCD_OFF_P3_DIR: begin
               st_nxt.p3_dir = pwdata[2:0];
               st_nxt.p3_pu  = pwdata[`GPCD_BIT_P3_PU];
               st_nxt.p4_pu  = pwdata[`GPCD_BIT_P4_PU];
            end
            `GPCD_OFF_ANSEL: begin
               st_nxt.ansel = pwdata[7:0];
            end
            default: begin
               // Unmapped and flag writes change no field here
            end
         endcase
      end

      if (clr_ok) begin
         st_nxt.chg_flag = 1'b0;
      end

      // Set wins over a simultaneous clear
      if (set_req || (|p2_miss)) begin
         st_nxt.chg_flag = 1'b1;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.bus      <= GPCD_IDLE;
         st_r.prdata   <= 32'h0000_0000;
         st_r.p2_lat   <= 8'h00;
         st_r.p2_dir   <= `GPCD_RST_DIR8;
         st_r.p2_ref   <= 4'h0;
         st_r.puen_n   <= `GPCD_RST_PUEN_N;
         st_r.chg_flag <= 1'b0;
         st_r.clr_hold <= 2'h0;
         st_r.p3_lat   <= 3'h0;
         st_r.p3_dir   <= `GPCD_RST_DIR3;
         st_r.p3_pu    <= 1'b0;
         st_r.p4_pu    <= 1'b0;
         st_r.ansel    <= `GPCD_RST_ANSEL;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : gpcd_port

// ************************************************************
// One pad: driver, pull-up gate, input gate, change compare
// ************************************************************
module gpcd_pad_cell
   import gpcd_pkg::*;
(
   input  wire logic pad_in,
   input  wire logic lat,
   input  wire logic dir,
   input  wire logic pu_req,
   input  wire logic analog,
   input  wire logic ref_val,
   input  wire logic watch,
   output logic      pad_out,
   output logic      pad_oe_n,
   output logic      pullup_on,
   output logic      din,
   output logic      miss
);

   assign pad_out   = lat;
   assign pad_oe_n  = dir;
   // Output pins never see the pull-up
   assign pullup_on = pu_req & dir;
   // Analog pins read as zero
   assign din       = pad_in & ~analog;
   // Only watched input pins compare against the reference
   assign miss      = watch & (din ^ ref_val);

endmodule : gpcd_pad_cell
`default_nettype wire

// file: core/gpcd_params.svh
// Register offsets, field positions, reset values for the port change block
`ifndef GPCD_PARAMS_SVH
`define GPCD_PARAMS_SVH
`define GPCD_OFF_P2_PINS   12'h000
`define GPCD_OFF_P2_LAT    12'h004
`define GPCD_OFF_P2_DIR    12'h008
`define GPCD_OFF_INTCTL    12'h00c
`define GPCD_OFF_INTCTL2   12'h010
`define GPCD_OFF_P3_PINS   12'h014
`define GPCD_OFF_P3_LAT    12'h018
`define GPCD_OFF_P3_DIR    12'h01c
`define GPCD_OFF_ANSEL     12'h020
`define GPCD_OFF_WAKE      12'h024
`define GPCD_BIT_PUEN_N    7
`define GPCD_BIT_CHG_FLAG  0
`define GPCD_BIT_P4_PU     7
`define GPCD_BIT_P3_PU     6
`define GPCD_RST_DIR8      8'hff
`define GPCD_RST_DIR3      3'h7
`define GPCD_RST_ANSEL     8'hff
`define GPCD_RST_PUEN_N    1'b1
`define GPCD_CLR_HOLD      2'h1
`endif

// file: core/gpcd_pkg.sv
// Types for the port change block
`default_nettype none
package gpcd_pkg;
   typedef enum logic [1:0] {
      GPCD_IDLE,
      GPCD_ACCESS
   } gpcd_bus_e;

   typedef struct packed {
      gpcd_bus_e   bus;
      logic [31:0] prdata;
      logic [7:0]  p2_lat;
      logic [7:0]  p2_dir;
      logic [3:0]  p2_ref;
      logic        puen_n;
      logic        chg_flag;
      logic [1:0]  clr_hold;
      logic [2:0]  p3_lat;
      logic [2:0]  p3_dir;
      logic        p3_pu;
      logic        p4_pu;
      logic [7:0]  ansel;
   } gpcd_state_s;
endpackage : gpcd_pkg
`default_nettype wire

// file: dv/gpcd_port_assertions.sv
// Checker on the port change block top ports
`default_nettype none
module gpcd_port_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [7:0]  p2_pad_out,
   input wire logic [7:0]  p2_pad_oe_n,
   input wire logic [7:0]  p2_pullup_on,
   input wire logic [2:0]  p3_pullup_on,
   input wire logic        p4_pullup_enable,
   input wire logic [7:0]  analog_select,
   input wire logic        wake_req
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   assign wr = psel && penable && pwrite;
   pu_off_a: assert property ((p2_pullup_on & ~p2_pad_oe_n) == 8'h00)
      else $error("pull-up on output pin");
   p4_pu_a: assert property (wr && paddr == 12'h01c |=> p4_pullup_enable == $past(pwdata[7]))
      else $error("fourth port pull-up wrong");
   p3_pu_a: assert property (wr && paddr == 12'h01c |=> p3_pullup_on == ({3{$past(pwdata[6])}} & $past(pwdata[2:0])))
      else $error("third port pull-up wrong");
   lat_hold_a: assert property (!(wr && paddr inside {12'h000, 12'h004}) |=> $stable(p2_pad_out))
      else $error("latch moved without write");
   p3_zero_a: assert property (psel && penable && !pwrite && paddr inside {12'h014, 12'h018} |-> prdata[31:3] == 29'h0)
      else $error("third port upper bits set");
   rst_pu_a: assert property ($rose(presetn) |-> p2_pullup_on == 8'h00)
      else $error("pull-ups on after reset");
   rst_an_a: assert property ($rose(presetn) |-> analog_select == 8'hff)
      else $error("pins not analog after reset");
   flag_clr_a: assert property ($fell(wake_req) |-> $past(wr))
      else $error("flag fell without write");
endmodule : gpcd_port_chk
bind gpcd_port gpcd_port_chk u_chk (.*);
`default_nettype wire

// file: dv/gpcd_pins.sv
// Pad model: outside drivers, weak pull-ups, floating pins
`default_nettype none
module gpcd_pins #(parameter int W = 8) (
   input  wire logic         pclk,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe_n,
   input  wire logic [W-1:0] pu,
   input  wire logic [W-1:0] ext,
   input  wire logic [W-1:0] ext_en,
   output logic      [W-1:0] lvl
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [W-1:0] flt = '0;
   always @(posedge pclk) flt <= ~flt;
   // Undriven, unpulled pin toggles every cycle
   assign lvl = (~oe_n & out) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & (pu | flt));
endmodule : gpcd_pins
`default_nettype wire

// file: dv/gpcd_port_tb.sv
// Self-checking bench for the port change block
`default_nettype none
module gpcd_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, rnd = 32'had630580;
   logic pready, pslverr, p4_pullup_enable, wake_req, err;
   logic [7:0] p2_pad_in, p2_pad_out, p2_pad_oe_n, p2_pullup_on, analog_select, e2 = '0, n2 = 8'hff;
   logic [2:0] p3_pad_in, p3_pad_out, p3_pad_oe_n, p3_pullup_on, e3 = '0;
   logic [11:0] ra [4] = '{12'h008, 12'h010, 12'h01c, 12'h020};
   logic [31:0] re [4] = '{32'hff, 32'h80, 32'h07, 32'hff};
   int miscompares = 0, comparisons = 0, cyc = 0;
   always #50 pclk = ~pclk;
   gpcd_port DUT (.*);
   gpcd_pins #(.W(8)) u_p2 (.pclk(pclk), .out(p2_pad_out), .oe_n(p2_pad_oe_n), .pu(p2_pullup_on), .ext(e2),
      .ext_en(n2), .lvl(p2_pad_in));
   gpcd_pins #(.W(3)) u_p3 (.pclk(pclk), .out(p3_pad_out), .oe_n(p3_pad_oe_n), .pu(p3_pullup_on), .ext(e3),
      .ext_en(3'h7), .lvl(p3_pad_in));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic finish_test();
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(negedge pclk);
   endtask : apb
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 0);
         chk("reset", re[i], rd);
      end
      apb(1'b0, 12'h000, 0);
      chk("analog pins", 0, rd[3:0]);
      chk("slverr mapped", 0, err);
      apb(1'b0, 12'h100, 0);
      chk("unmapped", 0, rd);
      chk("slverr unmapped", 1, err);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         apb(1'b1, 12'h004, rnd);
         apb(1'b1, 12'h008, rnd[15:8]);
         apb(1'b0, 12'h004, 0);
         chk("latch", rnd[7:0], rd);
         chk("drive", rnd[7:0] & ~rnd[15:8], p2_pad_out & ~p2_pad_oe_n);
         apb(1'b1, 12'h000, 0);
         apb(1'b0, 12'h004, 0);
         chk("pin clear", 0, rd);
      end
      @(posedge pclk) n2 <= 8'h0f;
      apb(1'b1, 12'h010, 0);
      apb(1'b1, 12'h008, 32'hf0);
      chk("pullup", 8'hf0, p2_pullup_on);
      apb(1'b0, 12'h000, 0);
      chk("pull level", 8'hf0, rd);
      @(posedge pclk) {n2, e2} <= 16'hfff0;
      apb(1'b0, 12'h000, 0);
      apb(1'b1, 12'h00c, 0);
      chk("quiet", 0, wake_req);
      @(posedge pclk) e2 <= 8'hd0;
      repeat (2) @(negedge pclk);
      chk("change", 1, wake_req);
      apb(1'b1, 12'h00c, 0);
      chk("set wins", 1, wake_req);
      apb(1'b0, 12'h024, 0);
      chk("wake reg", 1, rd);
      apb(1'b0, 12'h000, 0);
      apb(1'b1, 12'h00c, 0);
      chk("cleared", 0, wake_req);
      apb(1'b1, 12'h008, 32'hdf);
      apb(1'b1, 12'h004, 32'h20);
      apb(1'b0, 12'h000, 0);
      apb(1'b1, 12'h00c, 0);
      apb(1'b1, 12'h004, 0);
      repeat (2) @(negedge pclk);
      chk("excluded", 0, wake_req);
      rnd = lfsr(rnd);
      @(posedge pclk) e3 <= rnd[2:0];
      apb(1'b1, 12'h020, 32'h1f);
      apb(1'b0, 12'h014, 0);
      chk("p3 digital", rnd[2:0], rd);
      apb(1'b1, 12'h020, 32'hff);
      apb(1'b0, 12'h014, 0);
      chk("p3 analog", 0, rd);
      apb(1'b1, 12'h018, 32'hff);
      apb(1'b1, 12'h01c, 32'h80);
      chk("p3 drive", 3'h7, p3_pad_out & ~p3_pad_oe_n);
      chk("p4 pullup", 1, p4_pullup_enable);
      apb(1'b0, 12'h018, 0);
      chk("p3 latch", 32'h7, rd);
      apb(1'b1, 12'h01c, 32'h47);
      chk("p3 pullup", 3'h7, p3_pullup_on);
      finish_test();
   end
endmodule : gpcd_port_tb
`default_nettype wire
